// ===== include/fsar_pkg.sv
// Package of constants for the fault status and address register group.
package fsar_pkg;
  localparam logic [7:0]  FSAR_HFSTAT_OFF = 8'h2c;
  localparam logic [7:0]  FSAR_MMADDR_OFF = 8'h34;
  localparam logic [7:0]  FSAR_BFADDR_OFF = 8'h38;
  localparam logic [7:0]  FSAR_AUXST_OFF  = 8'h3c;
  localparam logic [7:0]  FSAR_VALID_OFF  = 8'h40;
  localparam logic [7:0]  FSAR_IRQST_OFF  = 8'h44;
  localparam logic [7:0]  FSAR_IRQMSK_OFF = 8'h48;
  localparam int          FSAR_VECT_BIT   = 1;
  localparam int          FSAR_FORCED_BIT = 30;
  localparam int          FSAR_DEBUG_BIT  = 31;
  localparam logic [31:0] FSAR_HF_MASK    = 32'hc000_0002;
  localparam logic [31:0] FSAR_ZERO       = 32'h0000_0000;
  localparam int          FSAR_MMV_BIT    = 0;
  localparam int          FSAR_BFV_BIT    = 1;
  localparam int          FSAR_EV_FORCED  = 0;
  localparam int          FSAR_EV_VECT    = 1;
  localparam int          FSAR_EV_AUX     = 2;
  localparam int          FSAR_EV_W       = 3;
endpackage

// ===== core/fsar_sticky.sv
// Sticky set / write-one-to-clear bit array.
`timescale 1ns/10ps
module fsar_sticky
  import fsar_pkg::*;
#(
  parameter int W = 32
)(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] q_o
);
  // Set wins over a clear in the same cycle so no event is lost.
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        q_o[i] <= 1'b0;
      else if (set_i[i])
        q_o[i] <= 1'b1;
      else if (clr_i[i])
        q_o[i] <= 1'b0;
    end
  end
endmodule // fsar_sticky

// ===== core/fsar_regs.sv
// Fault status and fault address register group with Wishbone slave.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/10ps
module fsar_regs
  import fsar_pkg::*;
#(
  parameter int AUX_W = 32
)(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  wb_err_o,
  input  wire logic             forced_fault_i,
  input  wire logic             vector_read_fault_i,
  input  wire logic             mm_fault_i,
  input  wire logic             mm_fault_addr_known_i,
  input  wire logic [31:0]      mm_fault_addr_i,
  input  wire logic             bus_fault_i,
  input  wire logic             bus_fault_addr_known_i,
  input  wire logic [31:0]      bus_fault_addr_i,
  input  wire logic [AUX_W-1:0] aux_fault_inputs_i,
  output logic                  irq_o
);
  // ********************************************************************
  // Bus decode
  // ********************************************************************
  logic        req;
  logic        wr;
  logic [31:0] wmask;
  logic        hit;
  logic        at_hf;
  logic        at_mm;
  logic        at_bf;
  logic        at_aux;
  logic        at_vld;
  logic        at_ist;
  logic        at_imsk;
  logic        wr_hf;
  logic        wr_mm;
  logic        wr_bf;
  logic        wr_aux;
  logic        wr_vld;
  logic        wr_ist;
  logic        wr_imsk;
  // A request already being answered is not taken again, so a master that
  // holds cyc and stb into the ack cycle cannot clear a flag twice.
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wr  = req && wb_we_i;
  // Byte lanes that sel leaves off keep their old contents.
  for (genvar b = 0; b < 4; b++)
  begin : g_lane
    assign wmask[8*b +: 8] = {8{wb_sel_i[b]}};
  end
  assign at_hf   = (wb_adr_i == FSAR_HFSTAT_OFF);
  assign at_mm   = (wb_adr_i == FSAR_MMADDR_OFF);
  assign at_bf   = (wb_adr_i == FSAR_BFADDR_OFF);
  assign at_aux  = (wb_adr_i == FSAR_AUXST_OFF);
  assign at_vld  = (wb_adr_i == FSAR_VALID_OFF);
  assign at_ist  = (wb_adr_i == FSAR_IRQST_OFF);
  assign at_imsk = (wb_adr_i == FSAR_IRQMSK_OFF);
  // Unmapped offsets are answered with err and change no state.
  assign hit     = at_hf || at_mm || at_bf || at_aux || at_vld || at_ist || at_imsk;
  assign wr_hf   = wr && at_hf;
  assign wr_mm   = wr && at_mm;
  assign wr_bf   = wr && at_bf;
  assign wr_aux  = wr && at_aux;
  assign wr_vld  = wr && at_vld;
  assign wr_ist  = wr && at_ist;
  assign wr_imsk = wr && at_imsk;

  // ********************************************************************
  // Hard fault status
  // ********************************************************************
  logic [31:0] hf_set;
  logic [31:0] hf_clr;
  logic [31:0] hard_fault_status_q;
  // The core stacks the address of the preempted instruction on a vector read
  // fault; this block only records that the fault happened.
  always_comb
  begin
    hf_set = FSAR_ZERO;
    hf_set[FSAR_FORCED_BIT] = forced_fault_i;
    hf_set[FSAR_VECT_BIT]   = vector_read_fault_i;
    hf_clr = FSAR_ZERO;
    if (wr_hf)
      hf_clr = wb_dat_i & wmask & FSAR_HF_MASK;
  end

  // Debug bit 31 is never set by this block; software must write zero there.
  fsar_sticky #(.W(32)) u_hf (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .set_i (hf_set & FSAR_HF_MASK),
    .clr_i (hf_clr),
    .q_o   (hard_fault_status_q)
  );

  // ********************************************************************
  // Auxiliary input synchroniser
  // ********************************************************************
  logic [AUX_W-1:0] aux_s1_q;
  logic [AUX_W-1:0] aux_s2_q;
  // Inputs come from outside, so two flops precede the latch; a one-cycle
  // pulse still passes intact, only delayed by two clocks.
  // The first stage is read only by the second, so metastability stays contained.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aux_s1_q <= '0;
      aux_s2_q <= '0;
    end
    else
    begin
      aux_s1_q <= aux_fault_inputs_i;
      aux_s2_q <= aux_s1_q;
    end
  end

  // ********************************************************************
  // Auxiliary fault status
  // ********************************************************************
  logic [AUX_W-1:0] aux_clr;
  logic [AUX_W-1:0] auxiliary_fault_status_q;
  // A write of zero leaves every auxiliary bit as it was.
  always_comb
  begin
    aux_clr = '0;
    if (wr_aux)
      aux_clr = AUX_W'(wb_dat_i & wmask);
  end

  fsar_sticky #(.W(AUX_W)) u_aux (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .set_i (aux_s2_q),
    .clr_i (aux_clr),
    .q_o   (auxiliary_fault_status_q)
  );

  // ********************************************************************
  // Fault address registers
  // ********************************************************************
  logic [31:0] memmgmt_fault_address_q;
  logic [31:0] bus_fault_address_q;
  // The core presents the actual faulting address for a memory fault and the
  // requested address for a bus fault; this block stores what it is given.
  // Capture wins over a software write in the same cycle, so a write in the
  // capture cycle cannot overwrite the address captured in that cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      memmgmt_fault_address_q <= FSAR_ZERO;
    else if (mm_fault_i && mm_fault_addr_known_i)
      memmgmt_fault_address_q <= mm_fault_addr_i;
    else if (wr_mm)
      memmgmt_fault_address_q <= (wb_dat_i & wmask) | (memmgmt_fault_address_q & ~wmask);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bus_fault_address_q <= FSAR_ZERO;
    else if (bus_fault_i && bus_fault_addr_known_i)
      bus_fault_address_q <= bus_fault_addr_i;
    else if (wr_bf)
      bus_fault_address_q <= (wb_dat_i & wmask) | (bus_fault_address_q & ~wmask);
  end

  // ********************************************************************
  // Address valid flags
  // ********************************************************************
  logic        memmgmt_addr_valid_q;
  logic        bus_addr_valid_q;
  // A fault of the other kind clears a flag, since the register it guards
  // no longer describes the latest fault.
  // Software clears either flag by writing a one to its bit.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bus_addr_valid_q <= 1'b0;
    else if (bus_fault_i && bus_fault_addr_known_i)
      bus_addr_valid_q <= 1'b1;
    else if (mm_fault_i)
      bus_addr_valid_q <= 1'b0;
    else if (wr_vld && wb_sel_i[0] && wb_dat_i[FSAR_BFV_BIT])
      bus_addr_valid_q <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      memmgmt_addr_valid_q <= 1'b0;
    else if (mm_fault_i && mm_fault_addr_known_i)
      memmgmt_addr_valid_q <= 1'b1;
    else if (bus_fault_i)
      memmgmt_addr_valid_q <= 1'b0;
    else if (wr_vld && wb_sel_i[0] && wb_dat_i[FSAR_MMV_BIT])
      memmgmt_addr_valid_q <= 1'b0;
  end

  // ********************************************************************
  // Interrupt status
  // ********************************************************************
  // Auxiliary faults never raise an exception; they reach software through
  // this interrupt and through the auxiliary fault status register.
  logic [FSAR_EV_W-1:0] ev_set;
  logic [FSAR_EV_W-1:0] ev_clr;
  logic [FSAR_EV_W-1:0] irq_status_q;
  always_comb
  begin
    ev_set = '0;
    ev_set[FSAR_EV_FORCED] = forced_fault_i;
    ev_set[FSAR_EV_VECT]   = vector_read_fault_i;
    ev_set[FSAR_EV_AUX]    = |aux_s2_q;
    ev_clr = '0;
    if (wr_ist && wb_sel_i[0])
      ev_clr = wb_dat_i[FSAR_EV_W-1:0];
  end

  // Set wins over a clear, so an event in the clear cycle stays pending.
  fsar_sticky #(.W(FSAR_EV_W)) u_irq (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .set_i (ev_set),
    .clr_i (ev_clr),
    .q_o   (irq_status_q)
  );

  // ********************************************************************
  // Interrupt mask and output
  // ********************************************************************
  logic [FSAR_EV_W-1:0] irq_mask_q;
  // Only enabled events reach the interrupt line.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_mask_q <= '0;
    else if (wr_imsk && wb_sel_i[0])
      irq_mask_q <= wb_dat_i[FSAR_EV_W-1:0];
  end

  // Registered so the interrupt line cannot glitch; it trails the status by one clock.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_status_q & irq_mask_q);
  end

  // ********************************************************************
  // Read data and acknowledge
  // ********************************************************************
  logic [31:0] rdata;
  // Reserved positions of the hard fault word are masked on every read.
  always_comb
  begin
    case (wb_adr_i)
      FSAR_HFSTAT_OFF: rdata = hard_fault_status_q & FSAR_HF_MASK;
      FSAR_MMADDR_OFF: rdata = memmgmt_fault_address_q;
      FSAR_BFADDR_OFF: rdata = bus_fault_address_q;
      FSAR_AUXST_OFF:  rdata = 32'(auxiliary_fault_status_q);
      FSAR_VALID_OFF:  rdata = {30'h0000_0000, bus_addr_valid_q, memmgmt_addr_valid_q};
      FSAR_IRQST_OFF:  rdata = 32'(irq_status_q);
      FSAR_IRQMSK_OFF: rdata = 32'(irq_mask_q);
      default:         rdata = FSAR_ZERO;
    endcase
  end

  // Every access, read or write, is answered one clock after it is taken.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req && hit;
  end

  // Err carries no data, so an unmapped read returns zero as well.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_err_o <= 1'b0;
    else
      wb_err_o <= req && !hit;
  end

  // Read data is zero outside a read ack, so an OR-combined bus needs no gate.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= FSAR_ZERO;
    else
      wb_dat_o <= (req && hit && !wb_we_i) ? rdata : FSAR_ZERO;
  end
endmodule // fsar_regs

// ===== sim/fsar_regs_asserts.sv
// Concurrent checks on the fault register group ports.
`timescale 1ns/10ps
module fsar_regs_asserts
  import fsar_pkg::*;
#(
  parameter int AUX_W = 32
)(
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [7:0]       wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             wb_err_o,
  input wire logic             forced_fault_i,
  input wire logic             vector_read_fault_i,
  input wire logic [AUX_W-1:0] aux_fault_inputs_i
);
  // ****************
  // Reference state.
  // ****************
  logic [31:0]      lm;
  logic             tk;
  logic             mp;
  logic [1:0]       hf_q;
  logic [AUX_W-1:0] s1_q, s2_q, ax_q;
  assign tk = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !wb_err_o;
  assign lm = wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign mp = wb_adr_i inside {FSAR_HFSTAT_OFF, FSAR_MMADDR_OFF, FSAR_BFADDR_OFF,
    FSAR_AUXST_OFF, FSAR_VALID_OFF, FSAR_IRQST_OFF, FSAR_IRQMSK_OFF};
  // The two sync stages mirror the input path, so a read sees the status one step late.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hf_q <= '0;
      s1_q <= '0;
      s2_q <= '0;
      ax_q <= '0;
    end
    else
    begin
      s1_q <= aux_fault_inputs_i;
      s2_q <= s1_q;
      hf_q <= {forced_fault_i, vector_read_fault_i}
        | (hf_q & ~({lm[30], lm[1]} & {2{tk && wb_adr_i == FSAR_HFSTAT_OFF}}));
      ax_q <= s2_q | (ax_q & ~(lm[AUX_W-1:0] & {AUX_W{tk && wb_adr_i == FSAR_AUXST_OFF}}));
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_rd(logic [7:0] a);
    s_req ##0 (!wb_we_i && wb_adr_i == a);
  endsequence
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_mapped: assert property (s_req ##0 mp |=> wb_ack_o && !wb_err_o)
    else $error("mapped access not acknowledged");
  a_err_unmapped: assert property (s_req ##0 !mp |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  a_err_pulse: assert property (wb_err_o |=> !wb_err_o)
    else $error("err longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == FSAR_ZERO)
    else $error("read data outside ack");
  a_hf_reserved: assert property (s_rd(FSAR_HFSTAT_OFF)
    |=> (wb_dat_o & ~FSAR_HF_MASK) == FSAR_ZERO)
    else $error("reserved status bits not zero");
  a_hf_flags: assert property (s_rd(FSAR_HFSTAT_OFF)
    |=> {wb_dat_o[30], wb_dat_o[1]} == $past(hf_q))
    else $error("hard fault flags wrong");
  a_aux_read: assert property (s_rd(FSAR_AUXST_OFF)
    |=> wb_dat_o[AUX_W-1:0] == $past(ax_q))
    else $error("auxiliary status wrong");
endmodule // fsar_regs_asserts

bind fsar_regs fsar_regs_asserts #(.AUX_W(AUX_W)) u_fsar_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .forced_fault_i(forced_fault_i), .vector_read_fault_i(vector_read_fault_i),
  .aux_fault_inputs_i(aux_fault_inputs_i));

// ===== sim/fsar_core_model.sv
// Behavioural model of the core's fault detection side.
`timescale 1ns/10ps
module fsar_core_model (
  input  wire logic        clk_i,
  input  wire logic [3:0]  ev_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] aux_i,
  output logic             f_o,
  output logic             v_o,
  output logic             mf_o,
  output logic             mk_o,
  output logic [31:0]      ma_o,
  output logic             bf_o,
  output logic             bk_o,
  output logic [31:0]      ba_o,
  output logic [31:0]      ax_o
);
  // ***************
  // Fault pulses.
  // ***************
  // Idle address lines flip so a stale value is never captured by luck.
  always_ff @(posedge clk_i)
  begin
    {bf_o, mf_o, v_o, f_o} <= ev_i;
    mk_o <= ev_i[2];
    bk_o <= ev_i[3];
    ma_o <= ev_i[2] ? addr_i + 32'h0000_0002 : ~ma_o;
    ba_o <= ev_i[3] ? addr_i : ~ba_o;
    ax_o <= aux_i;
  end
endmodule // fsar_core_model

// ===== sim/fsar_regs_tb.sv
// Self-checking testbench for the fault register group.
`timescale 1ns/10ps
module fsar_regs_tb
  import fsar_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        req = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  ev = 4'h0;
  logic [3:0]  sel = 4'hf;
  logic [31:0] dat = '0, addr = '0, aux = '0, got, rdat, ma, ba, ax;
  logic        ack, err, irq, got_err, f, v, mf, mk, bf, bk;
  int          n_errors = 0, n_tests = 0, cyc_n = 0;
  fsar_core_model i_core (.clk_i(clk_i), .ev_i(ev), .addr_i(addr), .aux_i(aux), .f_o(f),
    .v_o(v), .mf_o(mf), .mk_o(mk), .ma_o(ma), .bf_o(bf), .bk_o(bk), .ba_o(ba), .ax_o(ax));
  fsar_regs #(.AUX_W(32)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .forced_fault_i(f), .vector_read_fault_i(v),
    .mm_fault_i(mf), .mm_fault_addr_known_i(mk), .mm_fault_addr_i(ma), .bus_fault_i(bf),
    .bus_fault_addr_known_i(bk), .bus_fault_addr_i(ba), .aux_fault_inputs_i(ax), .irq_o(irq));
  // ****************
  // Bus and checks.
  // ****************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s = 4'hf);
    req <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    @(posedge clk_i);
    // Only the bench timeout ends a wait for the answer.
    while (ack !== 1'b1 && err !== 1'b1)
    begin
      @(posedge clk_i);
    end
    got = rdat;
    got_err = err;
    req <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, '0);
    chk(got, e);
  endtask
  task automatic pulse(input logic [3:0] k, input logic [31:0] a, input logic [31:0] x);
    ev <= k;
    addr <= a;
    aux <= x;
    @(posedge clk_i);
    ev <= 4'h0;
    aux <= '0;
    repeat (5) @(posedge clk_i);
  endtask
  task complete_run;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ***********
  // Scenarios.
  // ***********
  task automatic t_regs;
    rd(FSAR_HFSTAT_OFF, FSAR_ZERO);
    wb(1'b1, FSAR_HFSTAT_OFF, 32'h4000_0002);
    rd(FSAR_HFSTAT_OFF, FSAR_ZERO);
    wb(1'b1, FSAR_MMADDR_OFF, 32'h1234_5678);
    rd(FSAR_MMADDR_OFF, 32'h1234_5678);
    wb(1'b1, FSAR_MMADDR_OFF, 32'hffff_ffff, 4'h3);
    rd(FSAR_MMADDR_OFF, 32'h1234_ffff);
    wb(1'b1, FSAR_BFADDR_OFF, 32'h9abc_def0);
    rd(FSAR_BFADDR_OFF, 32'h9abc_def0);
    wb(1'b0, 8'h30, FSAR_ZERO);
    chk({31'h0, got_err}, 32'h0000_0001);
    $display("done regs");
  endtask
  task automatic t_hard;
    pulse(4'h1, '0, '0);
    rd(FSAR_HFSTAT_OFF, 32'h4000_0000);
    rd(FSAR_VALID_OFF, FSAR_ZERO);
    pulse(4'h2, '0, '0);
    rd(FSAR_HFSTAT_OFF, 32'h4000_0002);
    rd(FSAR_IRQST_OFF, 32'h0000_0003);
    wb(1'b1, FSAR_HFSTAT_OFF, 32'h0000_0002);
    rd(FSAR_HFSTAT_OFF, 32'h4000_0000);
    wb(1'b1, FSAR_HFSTAT_OFF, 32'h4000_0000);
    rd(FSAR_HFSTAT_OFF, FSAR_ZERO);
    $display("done hard");
  endtask
  task automatic t_addr;
    pulse(4'h4, 32'h2000_0011, '0);
    rd(FSAR_MMADDR_OFF, 32'h2000_0013);
    rd(FSAR_VALID_OFF, 32'h0000_0001);
    pulse(4'h8, 32'h4000_0021, '0);
    rd(FSAR_BFADDR_OFF, 32'h4000_0021);
    rd(FSAR_VALID_OFF, 32'h0000_0002);
    pulse(4'h4, 32'h0000_0100, '0);
    rd(FSAR_VALID_OFF, 32'h0000_0001);
    wb(1'b1, FSAR_VALID_OFF, 32'h0000_0001);
    rd(FSAR_VALID_OFF, FSAR_ZERO);
    $display("done addr");
  endtask
  task automatic t_aux;
    wb(1'b1, FSAR_IRQST_OFF, 32'h0000_0007);
    rd(FSAR_IRQST_OFF, FSAR_ZERO);
    pulse(4'h0, '0, 32'h8000_0001);
    rd(FSAR_AUXST_OFF, 32'h8000_0001);
    chk({31'h0, irq}, FSAR_ZERO);
    wb(1'b1, FSAR_AUXST_OFF, FSAR_ZERO);
    rd(FSAR_AUXST_OFF, 32'h8000_0001);
    wb(1'b1, FSAR_AUXST_OFF, 32'h0000_0001);
    rd(FSAR_AUXST_OFF, 32'h8000_0000);
    wb(1'b1, FSAR_IRQMSK_OFF, 32'h0000_0004);
    chk({31'h0, irq}, 32'h0000_0001);
    wb(1'b1, FSAR_IRQST_OFF, 32'h0000_0004);
    chk({31'h0, irq}, FSAR_ZERO);
    $display("done aux");
  endtask
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 5000)
    begin
      n_errors++;
      complete_run;
    end
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs;
    t_hard;
    t_addr;
    t_aux;
    complete_run;
  end
endmodule // fsar_regs_tb
